// [acsr_top.sv]
// acsr_top: status, result and test register logic of an 8-channel 10-bit converter.
// assumes a sample value from the analog front end and mode strobes from the chip.
`timescale 1ns/1ps
module acsr_top
    import acsr_pkg::*;
(
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    input  wire logic [7:0]  pin_input_levels,
    input  wire logic [9:0]  sample_value,
    input  wire logic        special_mode,
    input  wire logic        stop_mode,
    input  wire logic        wait_mode,
    output logic [2:0]       channel_select,
    output logic [3:0]       factory_test_select,
    output logic             test_output_mux
);
    // ========================================
    // register state
    logic        converter_power_up;
    logic        fast_flag_clear_select;
    logic        stop_in_wait;
    logic [6:0]  start_ctl;
    logic        sequence_done_flag;
    logic [7:0]  per_result_done_flags;
    logic [7:0]  status_seen;
    logic [2:0]  conversion_pointer;
    logic [9:0]  approximation_value_bits;
    logic [3:0]  test_sel;
    logic        test_out;
    logic [15:0] result_word [8];
    logic        first_seq_done;
    logic [7:0]  slot_cnt;
    acsr_state_e state;

    // ========================================
    // bus slave: write takes address and data in either order
    logic        aw_held;
    logic        w_held;
    logic [7:0]  aw_addr;
    logic [31:0] w_data;
    logic [3:0]  w_strb;
    logic        wr_go;
    logic        rd_go;
    logic        soft_rst;

    assign s_axi_awready = !aw_held && !s_axi_bvalid;
    assign s_axi_wready  = !w_held && !s_axi_bvalid;
    assign s_axi_arready = !s_axi_rvalid;
    assign s_axi_bresp   = 2'h0;
    assign s_axi_rresp   = 2'h0;
    assign wr_go         = aw_held && w_held;
    assign rd_go         = s_axi_arvalid && s_axi_arready;
    assign channel_select      = start_ctl[2:0] + (start_ctl[ST5_MULTICHANNEL_SELECT_BIT] ? conversion_pointer
                                                                            : 3'h0);
    assign factory_test_select = test_sel;
    assign test_output_mux     = test_out;

    // write channel capture and response
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_held      <= 1'b0;
            w_held       <= 1'b0;
            aw_addr      <= 8'h00;
            w_data       <= 32'h0000_0000;
            w_strb       <= 4'h0;
            s_axi_bvalid <= 1'b0;
        end
        else
        begin
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_held <= 1'b1;
                aw_addr <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_held <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end
            if (wr_go)
            begin
                aw_held      <= 1'b0;
                w_held       <= 1'b0;
                s_axi_bvalid <= 1'b1;
            end
            else if (s_axi_bvalid && s_axi_bready)
                s_axi_bvalid <= 1'b0;
        end
    end

    // decoded write strobes; full low half-word needed for the 10-bit approximation field
    logic wr_ct2;
    logic wr_start;
    logic wr_stat;
    logic wr_test;
    assign wr_ct2   = wr_go && aw_addr == OFS_CONTROL_TWO && w_strb[0];
    assign wr_start = wr_go && aw_addr == OFS_START && w_strb[0];
    assign wr_stat  = wr_go && aw_addr == OFS_STATUS && special_mode;
    assign wr_test  = wr_go && aw_addr == OFS_TEST && special_mode;
    assign soft_rst = wr_test && w_strb[1] && w_data[TST_RESET_BIT];

    // result read decode, used by both flag clearing paths
    function automatic logic is_result(input logic [7:0] a);
        return a[7:5] == OFS_RESULT_BASE[7:5] && a[1:0] == 2'h0;
    endfunction
    logic       rd_result;
    logic [2:0] rd_idx;
    logic       rd_status;
    assign rd_result = rd_go && is_result(s_axi_araddr);
    assign rd_idx    = s_axi_araddr[4:2];
    assign rd_status = rd_go && s_axi_araddr == OFS_STATUS;

    // ========================================
    // control register two; power-up survives soft reset
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            converter_power_up     <= 1'b0;
            fast_flag_clear_select <= 1'b0;
            stop_in_wait           <= 1'b0;
        end
        else if (wr_ct2)
        begin
            converter_power_up     <= w_data[CT2_POWER_BIT];
            fast_flag_clear_select <= w_data[CT2_FAST_BIT];
            stop_in_wait           <= w_data[CT2_STOP_IN_WAIT_BIT];
        end
        else if (soft_rst)
        begin
            fast_flag_clear_select <= 1'b0;
            stop_in_wait           <= 1'b0;
        end
    end

    // ========================================
    // sequencer: one conversion slot per CONV_CYCLES clocks
    logic halt;
    logic slot_end;
    logic seq_end;
    logic [2:0] last_ptr;
    // wait halts only with stop in wait
    assign halt     = stop_mode || (wait_mode && stop_in_wait) || !converter_power_up;
    assign slot_end = state == ACSR_RUN && !halt && slot_cnt == CONV_LAST;
    assign last_ptr = start_ctl[ST5_EIGHT_BIT] ? 3'h7 : 3'h3;
    assign seq_end  = slot_end && conversion_pointer == last_ptr;

    always_ff @(posedge aclk)
    begin
        if (!aresetn || soft_rst)
        begin
            state              <= ACSR_IDLE;
            start_ctl          <= 7'h00;
            slot_cnt           <= 8'h00;
            conversion_pointer <= 3'h0;
            first_seq_done     <= 1'b0;
        end
        else if (wr_start)
        begin
            state              <= ACSR_RUN;
            start_ctl          <= w_data[6:0];
            slot_cnt           <= 8'h00;
            conversion_pointer <= 3'h0;
            first_seq_done     <= 1'b0;
        end
        else
        begin
            case (state)
                ACSR_IDLE:
                    slot_cnt <= 8'h00;
                ACSR_RUN:
                begin
                    if (stop_mode)
                    begin
                        state              <= ACSR_IDLE;
                        conversion_pointer <= 3'h0;
                        slot_cnt           <= 8'h00;
                    end
                    else if (!halt)
                    begin
                        slot_cnt <= slot_end ? 8'h00 : slot_cnt + 8'h01;
                        if (slot_end)
                        begin
                            conversion_pointer <= seq_end ? 3'h0 : conversion_pointer + 3'h1;
                            if (seq_end)
                            begin
                                first_seq_done <= 1'b1;
                                if (!start_ctl[ST5_SCAN_BIT])
                                    state <= ACSR_IDLE;
                            end
                        end
                    end
                end
                default:
                    state <= ACSR_IDLE;
            endcase
        end
    end

    // ========================================
    // approximation register: tracks the sample, loadable in special mode
    always_ff @(posedge aclk)
    begin
        if (!aresetn || soft_rst)
            approximation_value_bits <= 10'h000;
        else if (wr_test && w_strb[0] && w_strb[1])
            approximation_value_bits <= w_data[9:0];
        else if (state == ACSR_RUN && !halt)
            approximation_value_bits <= sample_value;
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn || soft_rst)
        begin
            test_sel <= 4'h0;
            test_out <= 1'b0;
        end
        else if (wr_test && w_strb[1])
        begin
            test_sel <= w_data[TST_SEL_LSB +: 4];
            test_out <= w_data[TST_OUT_BIT];
        end
    end

    always_ff @(posedge aclk)
    begin
        if (slot_end)
            result_word[conversion_pointer] <= {approximation_value_bits, 6'h00};
    end

    // ========================================
    // sequence done flag; set wins over any clear in the same cycle except a start write or soft reset, which clear it
    logic seq_set;
    assign seq_set = seq_end && !first_seq_done;
    always_ff @(posedge aclk)
    begin
        if (!aresetn || soft_rst)
            sequence_done_flag <= 1'b0;
        else if (seq_set && !wr_start)
            sequence_done_flag <= 1'b1;
        else if (wr_start)
            sequence_done_flag <= 1'b0;
        else if (fast_flag_clear_select && rd_result)
            sequence_done_flag <= 1'b0;
        else if (wr_stat && w_strb[1])
            sequence_done_flag <= w_data[STAT_SEQ_BIT];
    end

    // per-result flags; status_seen marks flags observed by a status read
    logic [7:0] flag_set;
    logic [7:0] flag_clr;
    always_comb
    begin
        flag_set = 8'h00;
        flag_clr = 8'h00;
        if (slot_end)
            flag_set[conversion_pointer] = 1'b1;
        if (rd_result && (fast_flag_clear_select || status_seen[rd_idx]))
            flag_clr[rd_idx] = 1'b1;
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn || soft_rst || wr_start)
        begin
            per_result_done_flags <= 8'h00;
            status_seen           <= 8'h00;
        end
        else
        begin
            if (wr_stat && w_strb[0])
                per_result_done_flags <= (w_data[7:0] & ~flag_clr) | flag_set;
            else
                per_result_done_flags <= (per_result_done_flags & ~flag_clr) | flag_set;
            if (rd_status)
                status_seen <= per_result_done_flags & ~flag_set;
            else
                status_seen <= status_seen & ~flag_clr & ~flag_set;
        end
    end

    // ========================================
    // read data path, registered
    logic [31:0] next_rdata;
    always_comb
    begin
        next_rdata = 32'h0000_0000;
        if (is_result(s_axi_araddr))
            next_rdata = {16'h0000, result_word[rd_idx]};
        else
        begin
            case (s_axi_araddr)
                OFS_CONTROL_TWO: next_rdata = {24'h000000, converter_power_up,
                                               fast_flag_clear_select, stop_in_wait, 5'h00};
                OFS_START:       next_rdata = {25'h0000000, start_ctl};
                OFS_STATUS:      next_rdata = {16'h0000, sequence_done_flag, 4'h0,
                                               conversion_pointer, per_result_done_flags};
                OFS_TEST:        next_rdata = special_mode ?
                                     {16'h0000, test_out, 1'b0, test_sel, approximation_value_bits}
                                     : 32'h0000_0000;
                OFS_PINS:        next_rdata = {24'h000000, pin_input_levels};
                default:         next_rdata = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0000_0000;
        end
        else if (rd_go)
        begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= next_rdata;
        end
        else if (s_axi_rready)
            s_axi_rvalid <= 1'b0;
    end

    // ========================================
    // checks
    property p_start_clears;
        @(posedge aclk) disable iff (!aresetn) wr_start |=> !sequence_done_flag;
    endproperty
    a_start_clears: assert property (p_start_clears) else $error("start did not clear done");
    property p_done_sets;
        @(posedge aclk) disable iff (!aresetn || soft_rst)
            seq_set && !wr_start |=> sequence_done_flag;
    endproperty
    a_done_sets: assert property (p_done_sets) else $error("done flag not set");
    property p_fast_clear;
        @(posedge aclk) disable iff (!aresetn)
            fast_flag_clear_select && rd_result && !seq_set && !wr_stat |=> !sequence_done_flag;
    endproperty
    a_fast_clear: assert property (p_fast_clear) else $error("fast clear failed");
    property p_slow_hold;
        @(posedge aclk) disable iff (!aresetn || soft_rst)
            !fast_flag_clear_select && sequence_done_flag && !wr_start && !wr_stat
            |=> sequence_done_flag;
    endproperty
    a_slow_hold: assert property (p_slow_hold) else $error("done cleared early");
    property p_ptr_range;
        @(posedge aclk) disable iff (!aresetn)
            !start_ctl[ST5_EIGHT_BIT] |-> conversion_pointer <= 3'h3;
    endproperty
    a_ptr_range: assert property (p_ptr_range) else $error("pointer beyond four");
    property p_flag_on_end;
        @(posedge aclk) disable iff (!aresetn || soft_rst)
            slot_end && !wr_start |=> per_result_done_flags[$past(conversion_pointer)];
    endproperty
    a_flag_on_end: assert property (p_flag_on_end) else $error("result flag missing");
    property p_test_zero;
        @(posedge aclk) disable iff (!aresetn)
            rd_go && s_axi_araddr == OFS_TEST && !special_mode |=> s_axi_rdata == 32'h0;
    endproperty
    a_test_zero: assert property (p_test_zero) else $error("test read not zero");
    property p_unpowered_idle;
        @(posedge aclk) disable iff (!aresetn) !converter_power_up |-> !slot_end;
    endproperty
    a_unpowered_idle: assert property (p_unpowered_idle) else $error("converted unpowered");
    property p_stop_abort;
        @(posedge aclk) disable iff (!aresetn) stop_mode && !wr_start |=> state == ACSR_IDLE;
    endproperty
    a_stop_abort: assert property (p_stop_abort) else $error("stop did not abort");
    property p_soft_keep;
        @(posedge aclk) disable iff (!aresetn)
            soft_rst && !wr_ct2 |=> converter_power_up == $past(converter_power_up);
    endproperty
    a_soft_keep: assert property (p_soft_keep) else $error("soft reset lost power");
    c_seq_done: cover property (@(posedge aclk) disable iff (!aresetn) seq_set);
    c_fast_rd: cover property (@(posedge aclk) disable iff (!aresetn)
        fast_flag_clear_select && rd_result);
    c_scan: cover property (@(posedge aclk) disable iff (!aresetn)
        seq_end && first_seq_done);
endmodule

// [acsr_pkg.sv]
// acsr_pkg: register map, field positions and timing counts for the converter status block.
// assumes a 32-bit AXI4-Lite slave with one register per aligned word.
package acsr_pkg;
    // ========================================
    // register byte offsets
    localparam logic [7:0] OFS_CONTROL_TWO  = 8'h00; // power, fast clear, stop in wait
    localparam logic [7:0] OFS_START        = 8'h04; // conversion_start_control
    localparam logic [7:0] OFS_STATUS       = 8'h08; // conversion_status_flags
    localparam logic [7:0] OFS_TEST         = 8'h0C; // factory_test_and_approximation
    localparam logic [7:0] OFS_PINS         = 8'h10; // pin_digital_input
    localparam logic [7:0] OFS_RESULT_BASE  = 8'h20; // eight result words, high and low bytes
    // ========================================
    // field positions
    localparam int CT2_POWER_BIT    = 7;
    localparam int CT2_FAST_BIT     = 6;
    localparam int CT2_STOP_IN_WAIT_BIT     = 5;
    localparam int ST5_EIGHT_BIT    = 6;
    localparam int ST5_SCAN_BIT     = 5;
    localparam int ST5_MULTICHANNEL_SELECT_BIT     = 4;
    localparam int STAT_SEQ_BIT     = 15;
    localparam int TST_RESET_BIT    = 14;
    localparam int TST_OUT_BIT      = 15;
    localparam int TST_SEL_LSB      = 10;
    // ========================================
    // timing: one conversion slot in clock cycles
    localparam int CONV_TIME_NS     = 2000;
    localparam int CLK_PERIOD_NS    = 10;
    localparam int CONV_CYCLES      = CONV_TIME_NS / CLK_PERIOD_NS;
    localparam logic [7:0] CONV_LAST = 8'(CONV_CYCLES - 1);
    // sequencer states
    typedef enum logic [1:0]
    {
        ACSR_IDLE = 2'b00,
        ACSR_RUN  = 2'b01
    } acsr_state_e;
endpackage

// [acsr_pin_model.sv]
// acsr_pin_model: analog pin side seen by the converter status block.
// assumes the bench picks the pin levels and one sample value per channel.
`timescale 1ns/1ps
module acsr_pin_model
(
    input  wire logic [7:0]      pin_drive,
    input  wire logic [7:0][9:0] channel_values,
    input  wire logic [2:0]      channel_select,
    output logic [7:0]           pin_input_levels,
    output logic [9:0]           sample_value
);
    // ========================================
    // pins settle at once; no slew or threshold band is modelled
    assign pin_input_levels = pin_drive;
    // the front end presents whichever channel the sequencer selects
    assign sample_value = channel_values[channel_select];
endmodule

// [testbench.sv]
// testbench: drives acsr_top over AXI4-Lite and checks every read against a queue.
// assumes acsr_pin_model stands in for the analog pins and the front end.
`timescale 1ns/1ps
module testbench
    import acsr_pkg::*;
;
    localparam int          SEQ4 = 4 * CONV_CYCLES + 20;
    localparam int          STOP_RECOVERY = 50;
    localparam int          LIMIT = 20000;
    localparam logic [31:0] ALL = 32'hFFFFFFFF;
    localparam logic [31:0] SF = 32'h000080FF;
    logic              aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
    logic              special, stop, waitm;
    logic [7:0]        awaddr, araddr, pins;
    logic [31:0]       wdata;
    logic [3:0]        wstrb;
    logic [7:0][9:0]   ch;
    logic              awready, wready, bvalid, arready, rvalid, tmux;
    logic [1:0]        bresp, rresp;
    logic [31:0]       rdata;
    logic [2:0]        chan;
    logic [3:0]        fts;
    logic [7:0]        pin_lv;
    logic [9:0]        samp;
    int                failures = 0;
    int                comparisons = 0;
    int                cycles = 0;
    logic [31:0]       exp_q[$];
    logic [31:0]       msk_q[$];
    string             name_q[$];
    // ========================================
    // clock and the two models
    initial
    begin
        aclk = 1'b0;
        forever #5 aclk = ~aclk;
    end
    acsr_top i_acsr_top (.aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .pin_input_levels(pin_lv), .sample_value(samp), .special_mode(special),
        .stop_mode(stop), .wait_mode(waitm), .channel_select(chan),
        .factory_test_select(fts), .test_output_mux(tmux));
    acsr_pin_model i_acsr_pin_model (.pin_drive(pins), .channel_values(ch),
        .channel_select(chan), .pin_input_levels(pin_lv), .sample_value(samp));
    // ========================================
    // checking and bus tasks
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        comparisons++;
        if (g !== e)
        begin
            failures++;
            $display("[ERR] %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic end_of_test();
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    // address and data go out together; each drops on its own handshake
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        wstrb <= s;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do
        begin
            @(posedge aclk);
            if (awvalid && awready)
                awvalid <= 1'b0;
            if (wvalid && wready)
                wvalid <= 1'b0;
        end
        while (!bvalid);
        chk("bresp", 32'h0, {30'h0, bresp});
        bready <= 1'b0;
    endtask
    // the expectation is queued before the request so the monitor never runs dry
    task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m,
                      input string n);
        exp_q.push_back(e);
        msk_q.push_back(m);
        name_q.push_back(n);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do
        begin
            @(posedge aclk);
            if (arvalid && arready)
                arvalid <= 1'b0;
        end
        while (!rvalid);
        rready <= 1'b0;
    endtask
    function automatic logic [31:0] res(input int c);
        return {16'h0000, ch[c], 6'h00};
    endfunction
    // oldest expectation meets each read beat; masks hide fields left open
    always @(posedge aclk)
    begin
        if (rvalid && rready && exp_q.size() > 0)
        begin
            chk(name_q.pop_front(), exp_q.pop_front() & msk_q[0], rdata & msk_q[0]);
            void'(msk_q.pop_front());
            chk("rresp", 32'h0, {30'h0, rresp});
        end
    end
    // hang guard, well above the roughly eight thousand cycles the run needs
    always @(posedge aclk)
    begin
        cycles <= cycles + 1;
        if (cycles == LIMIT)
        begin
            failures++;
            end_of_test();
        end
    end
    // ========================================
    // main sequence
    initial
    begin
        {aresetn, awvalid, wvalid, bready, arvalid, rready, special, stop, waitm} = '0;
        {awaddr, araddr, wdata, wstrb} = '0;
        void'($urandom(32'h9505993B));
        pins = 8'($urandom());
        for (int i = 0; i < 8; i++)
            ch[i] = 10'($urandom());
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        rd(OFS_PINS, {24'h0, pins}, ALL, "pins");
        wr(OFS_PINS, {24'h0, ~pins}, 4'hF);
        rd(OFS_PINS, {24'h0, pins}, ALL, "pins");
        wr(OFS_TEST, 32'hA800, 4'h2);
        rd(OFS_TEST, 32'h0, ALL, "test_normal");
        chk("test_select", 32'h0, {28'h0, fts});
        wr(OFS_CONTROL_TWO, 32'h80, 4'h1);
        wr(OFS_START, 32'h06, 4'h1);
        repeat (SEQ4) @(posedge aclk);
        rd(OFS_RESULT_BASE, res(6), ALL, "result");
        rd(OFS_STATUS, 32'h800F, SF, "status");
        for (int i = 0; i < 2; i++)
            rd(OFS_RESULT_BASE + 8'(4 * i), res(6), ALL, "result");
        rd(OFS_STATUS, 32'h800C, SF, "status");
        wr(OFS_CONTROL_TWO, 32'hC0, 4'h1);
        wr(OFS_START, 32'h50, 4'h1);
        repeat (2 * SEQ4) @(posedge aclk);
        for (int i = 0; i < 8; i++)
            rd(OFS_RESULT_BASE + 8'(4 * i), res(i), ALL, "result");
        rd(OFS_STATUS, 32'h0, SF, "status");
        // restart, stop; pointer sits on step two mid-slot
        wr(OFS_START, 32'h06, 4'h1);
        repeat (2 * CONV_CYCLES + 20) @(posedge aclk);
        rd(OFS_STATUS, 32'h0200, 32'h0700, "pointer");
        wr(OFS_START, 32'h06, 4'h1);
        rd(OFS_STATUS, 32'h0, SF, "status");
        stop <= 1'b1;
        repeat (4) @(posedge aclk);
        stop <= 1'b0;
        repeat (SEQ4) @(posedge aclk);
        rd(OFS_STATUS, 32'h0, SF, "status");
        repeat (STOP_RECOVERY) @(posedge aclk);
        wr(OFS_CONTROL_TWO, 32'hA0, 4'h1);
        waitm <= 1'b1;
        wr(OFS_START, 32'h00, 4'h1);
        repeat (SEQ4) @(posedge aclk);
        rd(OFS_STATUS, 32'h0, SF, "status");
        waitm <= 1'b0;
        repeat (SEQ4) @(posedge aclk);
        rd(OFS_STATUS, 32'h800F, SF, "status");
        wr(OFS_CONTROL_TWO, 32'h40, 4'h1);
        wr(OFS_START, 32'h00, 4'h1);
        repeat (SEQ4) @(posedge aclk);
        rd(OFS_STATUS, 32'h0, SF, "status");
        rd(OFS_CONTROL_TWO, 32'h40, 32'hFF, "control_two");
        wr(OFS_CONTROL_TWO, 32'h80, 4'h1);
        wr(OFS_START, 32'h20, 4'h1);
        repeat (2 * SEQ4) @(posedge aclk);
        rd(OFS_STATUS, 32'h800F, SF, "status");
        special <= 1'b1;
        wr(OFS_TEST, 32'h4000, 4'h2);
        wr(OFS_TEST, 32'h0000, 4'h2);
        rd(OFS_CONTROL_TWO, 32'h80, 32'hFF, "control_two");
        rd(OFS_STATUS, 32'h0, SF, "status");
        wr(OFS_STATUS, 32'h8003, 4'h3);
        rd(OFS_STATUS, 32'h8003, SF, "status");
        wr(OFS_TEST, 32'h0155, 4'h3);
        rd(OFS_TEST, 32'h0155, 32'h3FF, "approx");
        wr(OFS_TEST, 32'hA800, 4'h2);
        repeat (2) @(posedge aclk);
        chk("test_select", 32'hA, {28'h0, fts});
        chk("test_out", 32'h1, {31'h0, tmux});
        end_of_test();
    end
endmodule
